// ===== msr_pkg.sv
// Package for the motor status and parameter register bank.
// Assumes a byte-wide register port driven by an I2C slave front end.
package msr_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_PERIOD_HIGH    = 8'h13;
  localparam logic [7:0] ADDR_PERIOD_LOW     = 8'h14;
  localparam logic [7:0] ADDR_VCONST_HIGH    = 8'h15;
  localparam logic [7:0] ADDR_VCONST_LOW     = 8'h16;
  localparam logic [7:0] ADDR_ROTOR_ANGLE    = 8'h19;
  localparam logic [7:0] ADDR_SUPPLY_LEVEL   = 8'h1A;
  localparam logic [7:0] ADDR_SPEED_REQUEST  = 8'h1B;
  localparam logic [7:0] ADDR_BUF_SPEED_REQ  = 8'h1C;
  localparam logic [7:0] ADDR_FAULT_FLAGS    = 8'h1E;
  localparam logic [7:0] ADDR_MOTOR_PARAM_ONE   = 8'h20;
  localparam logic [7:0] ADDR_MOTOR_PARAM_TWO   = 8'h21;
  localparam logic [7:0] ADDR_MOTOR_PARAM_THREE   = 8'h22;
  localparam logic [7:0] ADDR_SYS_OPTION1    = 8'h23;
  localparam logic [7:0] ADDR_SYS_OPTION2    = 8'h24;
  // Field masks and positions
  localparam logic [7:0] FAULT_MASK          = 8'h3F;
  localparam int         FLD_CODE_SHIFT_LSB  = 4;
  localparam int         FLD_MODE_BIT        = 7;
  localparam int         FLD_SPIN_DET_BIT    = 3;
  localparam int         FLD_REV_EN_BIT      = 2;
  // Reset values of the writable parameters
  localparam logic [7:0] PARAM_RESET         = 8'h00;
  // Timing: 20 MHz clock, PWM rates and advance time unit
  localparam int         CLK_HZ              = 20000000;
  localparam int         PWM_SLOW_HZ         = 25000;
  localparam int         PWM_FAST_HZ         = 50000;
  localparam int         PWM_SLOW_CYC        = CLK_HZ / PWM_SLOW_HZ;
  localparam int         PWM_FAST_CYC        = CLK_HZ / PWM_FAST_HZ;
  localparam int         ADV_UNIT_NS10       = 25;    // 2.5 us in 100 ns units
  localparam int         ADV_UNIT_CYC        = (ADV_UNIT_NS10 * 100) / 50;
  localparam int         PERIOD_UNIT_US      = 10;
  localparam int         PERIOD_UNIT_CYC     = PERIOD_UNIT_US * (CLK_HZ / 1000000);
endpackage

// ===== msr_pwm_tick.sv
// Switching-rate tick generator for the drive stage.
// Assumes clk at 20 MHz; emits a one-cycle pulse each PWM period.
`timescale 1ns/1ps
`default_nettype none
module msr_pwm_tick
  import msr_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic fast_sel,
  output logic      tick
);
  typedef struct packed {
    logic [9:0] cnt;
    logic       tick;
  } msr_pwm_s;
  msr_pwm_s st_r;
  msr_pwm_s st_nxt;
  logic [9:0] limit;

  // Divider picks 25 or 50 kHz
  always_comb begin
    limit = fast_sel ? 10'(PWM_FAST_CYC - 1) : 10'(PWM_SLOW_CYC - 1);
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt >= limit) begin
      st_nxt.cnt = 10'h000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 10'h001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule // msr_pwm_tick
`default_nettype wire

// ===== msr_regs.sv
// Operation
// - Period reported as 16 bits, high then low, ten microseconds per count.
// - Velocity constant 16 bits at two addresses, high byte first.
// - Rotor angle estimate byte includes configured advance angle.
// - Supply level byte; volts equal code times 22.8 over 256.
// - Active speed request byte from analog, PWM or bus; all ones full.
// - Buffered speed request shows bits 8 to 1 of internal value.
// - Fault byte bits 5..0 hold six fault flags; bits 7,6 zero.
// - Rate select bit chooses 25 kHz clear or 50 kHz set.
// - Phase resistance: shift count bits 6:4, mantissa bits 3:0.
// - Adjust mode bit: full cycle clear, half cycle set.
// - BEMF constant: shift count and mantissa, mantissa shifted by count.
// - Advance mode bit: fixed time clear, speed-dependent time set.
// - Advance delay equals 2.5 us times shifted mantissa.
// - Stationary threshold code 0..3 picks 6, 3, 1.6, 0.8 Hz.
// - Bits 5:4 pick advance after sensing: 30 to 120 degrees.
// - Bit 3 enables initial spin detection.
// - Reverse drive enable bit plus 2-bit start speed field.
// - Open-loop current field picks 0.2 to 1.6 amperes.
// - Open-loop ramp rate field, codes 0 to 7.
// - Brake field: code 0 disables, 1 to 7 pick brake time.
// - All registers reached as bytes over the serial interface.
// - Parameter writes take effect only while write unlock is set.
//
// Register bank for motor monitor and parameter bytes.
// Assumes an I2C slave front end gives byte reads and writes on clk.
`timescale 1ns/1ps
`default_nettype none
module msr_regs
  import msr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  // Byte access from the serial slave
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // Write unlock from the control register
  input  wire logic        config_write_unlock,
  // Core monitor values
  input  wire logic [15:0] electrical_period_value,
  input  wire logic [15:0] measured_velocity_constant,
  input  wire logic [7:0]  estimated_rotor_angle,
  input  wire logic [7:0]  supply_level_reading,
  input  wire logic [7:0]  speed_request_value,
  input  wire logic [8:0]  buffered_speed_request,
  input  wire logic [5:0]  fault_flags_in,
  // Decoded parameters to the motor core
  output logic             pwm_rate_select,
  output logic             pwm_tick,
  output logic [6:0]       phase_resistance_code,
  output logic [14:0]      phase_resistance_value,
  output logic             closed_loop_adjust_select,
  output logic [6:0]       bemf_constant_code,
  output logic [14:0]      bemf_constant_value,
  output logic             advance_timing_select,
  output logic [19:0]      advance_delay_cycles,
  output logic [1:0]       stationary_judge_threshold,
  output logic [1:0]       inductive_sense_advance_angle,
  output logic             spin_detect_enable,
  output logic             reverse_drive_enable,
  output logic [1:0]       reverse_drive_threshold,
  output logic [1:0]       open_loop_current_level,
  output logic [2:0]       open_loop_ramp_rate,
  output logic [2:0]       brake_duration,
  output logic             brake_enable
);
  typedef struct packed {
    logic [7:0]  rdata;
    logic        rvalid;
    logic [7:0]  period_lo_hold;
    logic [7:0]  vconst_lo_hold;
    logic [7:0]  param1;
    logic [7:0]  param2;
    logic [7:0]  param3;
    logic [7:0]  opt1;
    logic [7:0]  opt2;
    logic [14:0] res_val;
    logic [14:0] bemf_val;
    logic [19:0] adv_cyc;
    logic        brake_en;
    logic        tick;
  } msr_regs_s;

  msr_regs_s st_r;
  msr_regs_s st_nxt;
  logic      tick_w;

  // Drive-stage rate divider, steered by the rate select bit
  msr_pwm_tick u_pwm (
    .clk      (clk),
    .rst      (rst),
    .fast_sel (st_r.param1[FLD_MODE_BIT]),
    .tick     (tick_w)
  );

  // Shift-and-mantissa expansion shared by three fields
  function automatic logic [14:0] expand_code(input logic [6:0] code);
    logic [14:0] m;
    m = {11'h000, code[3:0]};
    expand_code = m << code[6:FLD_CODE_SHIFT_LSB];
  endfunction

  // Read mux, write decode and derived parameter values
  always_comb begin
    logic [7:0] rd;
    rd = 8'h00;
    st_nxt = st_r;
    st_nxt.rvalid = reg_rd;
    // Writes are gated by the unlock so a stray bus write cannot retune the motor
    if (reg_wr && config_write_unlock) begin
      case (reg_addr)
        ADDR_MOTOR_PARAM_ONE: st_nxt.param1 = reg_wdata;
        ADDR_MOTOR_PARAM_TWO: st_nxt.param2 = reg_wdata;
        ADDR_MOTOR_PARAM_THREE: st_nxt.param3 = reg_wdata;
        ADDR_SYS_OPTION1:  st_nxt.opt1   = reg_wdata;
        ADDR_SYS_OPTION2:  st_nxt.opt2   = reg_wdata;
        default:           st_nxt.opt2   = st_r.opt2;
      endcase
    end
    // Reading a high byte snapshots its low byte for a coherent pair
    case (reg_addr)
      ADDR_PERIOD_HIGH:   rd = electrical_period_value[15:8];
      ADDR_PERIOD_LOW:    rd = st_r.period_lo_hold;
      ADDR_VCONST_HIGH:   rd = measured_velocity_constant[15:8];
      ADDR_VCONST_LOW:    rd = st_r.vconst_lo_hold;
      ADDR_ROTOR_ANGLE:   rd = estimated_rotor_angle;
      ADDR_SUPPLY_LEVEL:  rd = supply_level_reading;
      ADDR_SPEED_REQUEST: rd = speed_request_value;
      ADDR_BUF_SPEED_REQ: rd = buffered_speed_request[8:1];
      ADDR_FAULT_FLAGS:   rd = {2'b00, fault_flags_in} & FAULT_MASK;
      ADDR_MOTOR_PARAM_ONE:  rd = st_r.param1;
      ADDR_MOTOR_PARAM_TWO:  rd = st_r.param2;
      ADDR_MOTOR_PARAM_THREE:  rd = st_r.param3;
      ADDR_SYS_OPTION1:   rd = st_r.opt1;
      ADDR_SYS_OPTION2:   rd = st_r.opt2;
      default:            rd = 8'h00;
    endcase
    if (reg_rd) begin
      st_nxt.rdata = rd;
      if (reg_addr == ADDR_PERIOD_HIGH) begin
        st_nxt.period_lo_hold = electrical_period_value[7:0];
      end
      if (reg_addr == ADDR_VCONST_HIGH) begin
        st_nxt.vconst_lo_hold = measured_velocity_constant[7:0];
      end
    end
    // Decoded values are registered to keep outputs off the write path
    st_nxt.res_val  = expand_code(st_r.param1[6:0]);
    st_nxt.bemf_val = expand_code(st_r.param2[6:0]);
    st_nxt.adv_cyc  = 20'(expand_code(st_r.param3[6:0])) * 20'(ADV_UNIT_CYC);
    st_nxt.brake_en = (st_r.opt2[2:0] != 3'b000);
    // Tick is buffered once so every output leaves a flip-flop
    st_nxt.tick     = tick_w;
  end

  // Single state register; parameters clear at reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Field outputs straight from the state register
  assign reg_rdata                     = st_r.rdata;
  assign reg_rvalid                    = st_r.rvalid;
  assign pwm_rate_select               = st_r.param1[FLD_MODE_BIT];
  assign pwm_tick                      = st_r.tick;
  assign phase_resistance_code         = st_r.param1[6:0];
  assign phase_resistance_value        = st_r.res_val;
  assign closed_loop_adjust_select     = st_r.param2[FLD_MODE_BIT];
  assign bemf_constant_code            = st_r.param2[6:0];
  assign bemf_constant_value           = st_r.bemf_val;
  assign advance_timing_select         = st_r.param3[FLD_MODE_BIT];
  assign advance_delay_cycles          = st_r.adv_cyc;
  assign stationary_judge_threshold    = st_r.opt1[7:6];
  assign inductive_sense_advance_angle = st_r.opt1[5:4];
  assign spin_detect_enable            = st_r.opt1[FLD_SPIN_DET_BIT];
  assign reverse_drive_enable          = st_r.opt1[FLD_REV_EN_BIT];
  assign reverse_drive_threshold       = st_r.opt1[1:0];
  assign open_loop_current_level       = st_r.opt2[7:6];
  assign open_loop_ramp_rate           = st_r.opt2[5:3];
  assign brake_duration                = st_r.opt2[2:0];
  assign brake_enable                  = st_r.brake_en;
endmodule // msr_regs
`default_nettype wire

// ===== msr_props.sv
// Port checker for the motor register bank.
// Assumes it is bound onto msr_regs and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module msr_props
  import msr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        config_write_unlock,
  input wire logic [7:0]  estimated_rotor_angle,
  input wire logic [8:0]  buffered_speed_request,
  input wire logic [5:0]  fault_flags_in,
  input wire logic        pwm_rate_select,
  input wire logic [6:0]  phase_resistance_code,
  input wire logic [14:0] phase_resistance_value,
  input wire logic [2:0]  brake_duration,
  input wire logic        brake_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Read answers and decoded values, each tied to its cause one cycle back
  property p_rv; 1 |=> reg_rvalid == $past(reg_rd); endproperty
  a_rv: assert property (p_rv) else $error("read valid mismatch");
  property p_flt; reg_rd && reg_addr == ADDR_FAULT_FLAGS |=> reg_rdata == {2'b00, $past(fault_flags_in)}; endproperty
  a_flt: assert property (p_flt) else $error("fault byte mismatch");
  property p_ang; reg_rd && reg_addr == ADDR_ROTOR_ANGLE |=> reg_rdata == $past(estimated_rotor_angle); endproperty
  a_ang: assert property (p_ang) else $error("angle byte mismatch");
  property p_buf; reg_rd && reg_addr == ADDR_BUF_SPEED_REQ |=> reg_rdata == $past(buffered_speed_request[8:1]); endproperty
  a_buf: assert property (p_buf) else $error("buffered speed mismatch");
  property p_rate; reg_wr && config_write_unlock && reg_addr == ADDR_MOTOR_PARAM_ONE |=> pwm_rate_select == $past(reg_wdata[7]); endproperty
  a_rate: assert property (p_rate) else $error("rate select not written");
  property p_lock; !config_write_unlock |=> $stable(phase_resistance_code); endproperty
  a_lock: assert property (p_lock) else $error("locked parameter changed");
  property p_res; 1 |=> phase_resistance_value == (15'($past(phase_resistance_code[3:0])) << $past(phase_resistance_code[6:4])); endproperty
  a_res: assert property (p_res) else $error("resistance value mismatch");
  property p_brk; 1 |=> brake_enable == ($past(brake_duration) != 3'h0); endproperty
  a_brk: assert property (p_brk) else $error("brake enable mismatch");
endmodule // msr_props
bind msr_regs msr_props i_props (.*);
`default_nettype wire

// ===== msr_host.sv
// Host model issuing byte reads and writes to the bank.
// Assumes clk from the bench; changes its lines on falling edges only.
`timescale 1ns/1ps
`default_nettype none
module msr_host
  import msr_pkg::*;
(
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  end
  // Lines flipped after release so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // Unknown result when no valid pulse came back
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rvalid ? reg_rdata : 8'hXX;
  endtask
endmodule // msr_host
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the motor register bank.
// Assumes msr_host drives the byte port and msr_props is bound in.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import msr_pkg::*;
  logic clk = 1'b0, rst = 1'b1, config_write_unlock = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, estimated_rotor_angle, supply_level_reading;
  logic [7:0] speed_request_value, d, h, l, m [5];
  logic reg_wr, reg_rd, reg_rvalid, pwm_rate_select, pwm_tick, closed_loop_adjust_select;
  logic advance_timing_select, spin_detect_enable, reverse_drive_enable, brake_enable;
  logic [15:0] electrical_period_value, measured_velocity_constant, p, v;
  logic [8:0] buffered_speed_request;
  logic [5:0] fault_flags_in;
  logic [6:0] phase_resistance_code, bemf_constant_code;
  logic [14:0] phase_resistance_value, bemf_constant_value;
  logic [19:0] advance_delay_cycles;
  logic [1:0] stationary_judge_threshold, inductive_sense_advance_angle, reverse_drive_threshold;
  logic [1:0] open_loop_current_level;
  logic [2:0] open_loop_ramp_rate, brake_duration;
  int fails = 0, n_tests = 0, c;
  msr_regs i_dut (.*);
  msr_host i_host (.*);
  always #25 clk = ~clk;
  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude();
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Whole run is at most about 3400 cycles; this limit means a hang
  initial begin
    #(50 * 30000);
    fails++;
    conclude();
  end
  initial begin
    void'($urandom(32'h9223));
    {electrical_period_value, measured_velocity_constant, estimated_rotor_angle} = '0;
    {supply_level_reading, speed_request_value, buffered_speed_request, fault_flags_in} = '0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    // Locked writes must leave the zero reset values
    for (int i = 0; i < 5; i++) begin
      i_host.wr(ADDR_MOTOR_PARAM_ONE + 8'(i), 8'($urandom));
      i_host.rd(ADDR_MOTOR_PARAM_ONE + 8'(i), d);
      chk("param", 8'h00, d);
    end
    config_write_unlock = 1'b1;
    for (int k = 0; k < 24; k++) begin
      // Fresh core values each pass; low bytes must come from the snapshot
      {p, v, estimated_rotor_angle, supply_level_reading} = 48'({$urandom, $urandom});
      {speed_request_value, buffered_speed_request, fault_flags_in} = 23'($urandom);
      {electrical_period_value, measured_velocity_constant} = {p, v};
      i_host.rd(ADDR_PERIOD_HIGH, h);
      electrical_period_value = ~p;
      i_host.rd(ADDR_PERIOD_LOW, l);
      chk("period", p, {h, l});
      i_host.rd(ADDR_VCONST_HIGH, h);
      measured_velocity_constant = ~v;
      i_host.rd(ADDR_VCONST_LOW, l);
      chk("vconst", v, {h, l});
      i_host.rd(ADDR_ROTOR_ANGLE, d);
      chk("angle", estimated_rotor_angle, d);
      i_host.rd(ADDR_SUPPLY_LEVEL, d);
      chk("supply", supply_level_reading, d);
      i_host.rd(ADDR_SPEED_REQUEST, d);
      chk("speed", speed_request_value, d);
      i_host.rd(ADDR_BUF_SPEED_REQ, d);
      chk("bufspeed", buffered_speed_request[8:1], d);
      i_host.rd(ADDR_FAULT_FLAGS, d);
      chk("fault", {2'b00, fault_flags_in}, d);
      i_host.rd(8'h17, d);
      chk("unmapped", 8'h00, d);
      for (int i = 0; i < 5; i++) begin
        m[i] = 8'($urandom);
        if (i == 4) m[i][2:0] = k[2:0];
        i_host.wr(ADDR_MOTOR_PARAM_ONE + 8'(i), m[i]);
        i_host.rd(ADDR_MOTOR_PARAM_ONE + 8'(i), d);
        chk("param", m[i], d);
      end
      // Decoded outputs against the bench's own register copy
      chk("rate", m[0][7], pwm_rate_select);
      chk("rescode", m[0][6:0], phase_resistance_code);
      chk("resval", 15'(m[0][3:0]) << m[0][6:4], phase_resistance_value);
      chk("adjust", m[1][7], closed_loop_adjust_select);
      chk("bemfcode", m[1][6:0], bemf_constant_code);
      chk("bemfval", 15'(m[1][3:0]) << m[1][6:4], bemf_constant_value);
      chk("advsel", m[2][7], advance_timing_select);
      chk("advdelay", (int'(m[2][3:0]) << m[2][6:4]) * 50, advance_delay_cycles);
      chk("opt1", m[3], {stationary_judge_threshold, inductive_sense_advance_angle,
          spin_detect_enable, reverse_drive_enable, reverse_drive_threshold});
      chk("opt2", m[4], {open_loop_current_level, open_loop_ramp_rate, brake_duration});
      chk("brake", m[4][2:0] != 3'h0, brake_enable);
    end
    // Tick spacing for both rates; first gap may still run at the old rate
    for (int s = 0; s < 2; s++) begin
      i_host.wr(ADDR_MOTOR_PARAM_ONE, {s[0], 7'h00});
      for (int w = 0; w < 2; w++) begin
        c = 0;
        do begin
          @(negedge clk);
          c++;
        end while (pwm_tick !== 1'b1 && c < 900);
      end
      chk("tick", s ? PWM_FAST_CYC : PWM_SLOW_CYC, c);
    end
    // Mid-run reset clears the parameters again
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    i_host.rd(ADDR_SYS_OPTION2, d);
    chk("rstparam", 8'h00, d);
    conclude();
  end
endmodule // tb
`default_nettype wire
